//--- spc_pkg.sv
// What this block does
// RL1: control bit 7 enables forwarding of the port's interrupt to host.
// RL2: control bits 6-4 choose host interrupt line in serial-IRQ stream.
// RL3: control bits 3-0 choose decoded I/O base address of the port.
// RL4: port one control resets to disabled, line code 001, base 0000.
// RL5: port two control resets to disabled, line code 000, base 0001.
// RL6: control and mode registers return to defaults only on platform reset.
// RL7: 422/485 auto mode drives transmitter while bytes are pending.
// RL8: 422/485 manual mode: rts low enables driver, rts high tri-states.
// RL9: host software should clear rts before sending in manual mode.
// RL10: under power-managed os host only reads port one control.
// RL11: mode register bit 4 enables port one auto direction, default 0.
// RL12: base codes 1010 to 1111 decode no i/o range at all.
package spc_pkg;
   localparam int          CTL_W        = 8;
   localparam int          IEN_BIT      = 7;
   localparam int          IRQ_HI       = 6;
   localparam int          IRQ_LO       = 4;
   localparam int          BASE_HI      = 3;
   localparam int          BASE_LO      = 0;
   localparam int          ADC_ONE_BIT  = 4;
   localparam int          ADC_TWO_BIT  = 5;
   localparam int          IO_W         = 16;
   localparam logic [7:0]  PORT_ONE_RST = 8'h10;
   localparam logic [7:0]  PORT_TWO_RST = 8'h01;
   localparam logic [7:0]  MODE_RST     = 8'h00;
   localparam logic [7:0]  MODE_MASK    = 8'h30;
   localparam logic [15:0] PORT_SPAN    = 16'h0007;
   // host interrupt line numbers per select code
   localparam logic [3:0]  IRQ_3  = 4'h3;
   localparam logic [3:0]  IRQ_4  = 4'h4;
   localparam logic [3:0]  IRQ_5  = 4'h5;
   localparam logic [3:0]  IRQ_6  = 4'h6;
   localparam logic [3:0]  IRQ_7  = 4'h7;
   localparam logic [3:0]  IRQ_9  = 4'h9;
   localparam logic [3:0]  IRQ_10 = 4'ha;
   localparam logic [3:0]  IRQ_11 = 4'hb;
   localparam logic [15:0] BASE_0 = 16'h03f8;
   localparam logic [15:0] BASE_1 = 16'h02f8;
   localparam logic [15:0] BASE_2 = 16'h03e8;
   localparam logic [15:0] BASE_3 = 16'h02e8;
   localparam logic [15:0] BASE_4 = 16'h0200;
   localparam logic [15:0] BASE_5 = 16'h0220;
   localparam logic [15:0] BASE_6 = 16'h0228;
   localparam logic [15:0] BASE_7 = 16'h0338;
   localparam logic [15:0] BASE_8 = 16'h0238;
   localparam logic [15:0] BASE_9 = 16'h0338;
endpackage

//--- spc_port.sv
`timescale 1ns/100ps
`default_nettype none
// per-port decode of one control register and direction control
module spc_port (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  ctl,
   input  wire logic        auto_dir,
   input  wire logic        xcvr_485,
   input  wire logic        tx_pending,
   input  wire logic        rts,
   input  wire logic        uart_irq,
   input  wire logic [15:0] io_addr,
   output logic             io_hit,
   output logic             irq_valid,
   output logic [3:0]       irq_line,
   output logic             tx_drive
);
   logic [15:0] base;
   logic        base_ok;
   logic        next_irq_valid;
   logic [3:0]  next_irq_line;
   logic        next_tx_drive;

   // base address from select code; reserved codes decode nothing
   always_comb begin
      base_ok = 1'b1;
      unique case (ctl[spc_pkg::BASE_HI:spc_pkg::BASE_LO]) // RL3
         4'h0: base = spc_pkg::BASE_0;
         4'h1: base = spc_pkg::BASE_1;
         4'h2: base = spc_pkg::BASE_2;
         4'h3: base = spc_pkg::BASE_3;
         4'h4: base = spc_pkg::BASE_4;
         4'h5: base = spc_pkg::BASE_5;
         4'h6: base = spc_pkg::BASE_6;
         4'h7: base = spc_pkg::BASE_7;
         4'h8: base = spc_pkg::BASE_8;
         4'h9: base = spc_pkg::BASE_9;
         default: begin
            base    = 16'h0000;
            base_ok = 1'b0; // RL12
         end
      endcase
   end

   assign io_hit = base_ok &&
                   ((io_addr & ~spc_pkg::PORT_SPAN) == base); // RL3

   // interrupt gating, line mapping and transmit direction
   always_comb begin
      next_irq_valid = uart_irq & ctl[spc_pkg::IEN_BIT]; // RL1
      unique case (ctl[spc_pkg::IRQ_HI:spc_pkg::IRQ_LO]) // RL2
         3'h0: next_irq_line = spc_pkg::IRQ_3;
         3'h1: next_irq_line = spc_pkg::IRQ_4;
         3'h2: next_irq_line = spc_pkg::IRQ_5;
         3'h3: next_irq_line = spc_pkg::IRQ_10;
         3'h4: next_irq_line = spc_pkg::IRQ_6;
         3'h5: next_irq_line = spc_pkg::IRQ_7;
         3'h6: next_irq_line = spc_pkg::IRQ_9;
         3'h7: next_irq_line = spc_pkg::IRQ_11;
      endcase
      if (!xcvr_485)
         next_tx_drive = 1'b1;
      else if (auto_dir)
         next_tx_drive = tx_pending; // RL7
      else
         next_tx_drive = ~rts; // RL8
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_valid <= 1'b0;
         irq_line  <= spc_pkg::IRQ_3;
         tx_drive  <= 1'b1;
      end else begin
         irq_valid <= next_irq_valid;
         irq_line  <= next_irq_line;
         tx_drive  <= next_tx_drive;
      end
   end

   tx_auto_a: assert property (@(posedge clk) disable iff (sys_rst)
      xcvr_485 && auto_dir |=> tx_drive == $past(tx_pending)) // RL7
      else $error("auto direction does not follow pending bytes");
   tx_manual_a: assert property (@(posedge clk) disable iff (sys_rst)
      xcvr_485 && !auto_dir |=> tx_drive == !$past(rts)) // RL8
      else $error("manual direction does not follow rts");
   irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      !ctl[spc_pkg::IEN_BIT] |=> !irq_valid) // RL1
      else $error("interrupt forwarded while disabled");
   irq_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
      ctl[spc_pkg::IEN_BIT] && uart_irq |=> irq_valid) // RL1
      else $error("enabled interrupt not forwarded");
   reserved_base_a: assert property (@(posedge clk) disable iff (sys_rst)
      ctl[spc_pkg::BASE_HI:spc_pkg::BASE_LO] > 4'h9 |-> !io_hit) // RL12
      else $error("reserved base code decodes an address");
   irq_map_a: assert property (@(posedge clk) disable iff (sys_rst)
      ctl[spc_pkg::IRQ_HI:spc_pkg::IRQ_LO] == 3'h3 |=> irq_line == 4'ha)
      // RL2
      else $error("line code 011 does not map to irq10");
   auto_tx_c: cover property (@(posedge clk)
      xcvr_485 && auto_dir && tx_pending ##1 !tx_pending);
   irq_fwd_c: cover property (@(posedge clk) irq_valid);
   hit_c: cover property (@(posedge clk) io_hit);
endmodule // spc_port
`default_nettype wire

//--- spc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// two serial port control registers, mode register, per-port decode
module spc_ctrl (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        one_ctl_we,
   input  wire logic        two_ctl_we,
   input  wire logic        mode_we,
   input  wire logic [7:0]  wdata,
   input  wire logic [1:0]  xcvr_485,
   input  wire logic [1:0]  tx_pending,
   input  wire logic [1:0]  rts,
   input  wire logic [1:0]  uart_irq,
   input  wire logic [15:0] io_addr,
   output logic [7:0]       one_ctl,
   output logic [7:0]       two_ctl,
   output logic [7:0]       mode_reg,
   output logic [1:0]       io_hit,
   output logic [1:0]       irq_valid,
   output logic [7:0]       irq_line,
   output logic [1:0]       tx_drive
);
   logic [7:0] next_one_ctl;
   logic [7:0] next_two_ctl;
   logic [7:0] next_mode_reg;
   logic [1:0] auto_dir;

   // register writes; only the platform reset restores defaults
   always_comb begin
      next_one_ctl  = one_ctl_we ? wdata : one_ctl;
      next_two_ctl  = two_ctl_we ? wdata : two_ctl;
      next_mode_reg = mode_we ? (wdata & spc_pkg::MODE_MASK) : mode_reg;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin // RL6
         one_ctl  <= spc_pkg::PORT_ONE_RST; // RL4
         two_ctl  <= spc_pkg::PORT_TWO_RST; // RL5
         mode_reg <= spc_pkg::MODE_RST; // RL11
      end else begin
         one_ctl  <= next_one_ctl;
         two_ctl  <= next_two_ctl;
         mode_reg <= next_mode_reg;
      end
   end

   assign auto_dir = {mode_reg[spc_pkg::ADC_TWO_BIT],
                      mode_reg[spc_pkg::ADC_ONE_BIT]}; // RL11

   // one decode slice per port
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_port
         spc_port u_port (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .ctl        (g == 0 ? one_ctl : two_ctl),
            .auto_dir   (auto_dir[g]),
            .xcvr_485   (xcvr_485[g]),
            .tx_pending (tx_pending[g]),
            .rts        (rts[g]),
            .uart_irq   (uart_irq[g]),
            .io_addr    (io_addr),
            .io_hit     (io_hit[g]),
            .irq_valid  (irq_valid[g]),
            .irq_line   (irq_line[g*4 +: 4]),
            .tx_drive   (tx_drive[g])
         );
      end
   endgenerate

   one_reset_a: assert property (@(posedge clk)
      sys_rst |=> one_ctl == 8'h10) // RL4
      else $error("port one control default wrong");
   two_reset_a: assert property (@(posedge clk)
      sys_rst |=> two_ctl == 8'h01) // RL5
      else $error("port two control default wrong");
   hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !one_ctl_we && !two_ctl_we |=> $stable(one_ctl) && $stable(two_ctl))
      // RL6
      else $error("control register changed without write");
   mode_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      mode_we |=> mode_reg[4] == $past(wdata[4])) // RL11
      else $error("auto direction bit not stored");
   write_c: cover property (@(posedge clk) one_ctl_we ##1 two_ctl_we);
endmodule // spc_ctrl
`default_nettype wire

//--- spc_far.sv
`timescale 1ns/100ps
`default_nettype none
// uart core levels as host software leaves them
module spc_far (
   input  wire logic       clk,
   input  wire logic [7:0] cmd,
   output logic [1:0]      xcvr,
   output logic [1:0]      pend,
   output logic [1:0]      rts,
   output logic [1:0]      irq
);
   // levels move once per clock, like the core's own flops
   always_ff @(posedge clk) begin
      xcvr <= cmd[1:0];
      pend <= cmd[3:2];
      rts  <= cmd[5:4] & ~cmd[3:2];
      irq  <= cmd[7:6];
   end
endmodule // spc_far
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        we1 = 1'b0;
   logic        we2 = 1'b0;
   logic        wem = 1'b0;
   logic        chk = 1'b0;
   logic [7:0]  wd = 8'h00;
   logic [7:0]  cmd = 8'h00;
   logic [15:0] ioa = 16'h03fc;
   logic [31:0] r;
   logic [7:0]  o, t, m, oc, tc, mr, il;
   logic [1:0]  xc, pe, rt, ir, hit, iv, td;
   logic [39:0] q [$];
   logic [15:0] bt [10] = '{16'h03f8, 16'h02f8, 16'h03e8, 16'h02e8,
      16'h0200, 16'h0220, 16'h0228, 16'h0338, 16'h0238, 16'h0338};
   logic [3:0]  it [8] = '{4'h3, 4'h4, 4'h5, 4'ha, 4'h6, 4'h7, 4'h9, 4'hb};
   int          err_total = 0;
   int          total_checks = 0;
   // free-running clock
   always #10 clk = ~clk;
   spc_ctrl spc_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .one_ctl_we(we1),
      .two_ctl_we(we2), .mode_we(wem), .wdata(wd), .xcvr_485(xc),
      .tx_pending(pe), .rts(rt), .uart_irq(ir), .io_addr(ioa),
      .one_ctl(oc), .two_ctl(tc), .mode_reg(mr), .io_hit(hit),
      .irq_valid(iv), .irq_line(il), .tx_drive(td));
   spc_far spc_far_inst (.clk(clk), .cmd(cmd), .xcvr(xc), .pend(pe),
      .rts(rt), .irq(ir));
   task automatic check(logic [39:0] got, logic [39:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // expected port view from the register model
   function automatic logic [39:0] ex();
      logic [7:0] c;
      logic [1:0] h, v, d;
      for (int p = 0; p < 2; p++) begin
         c = p ? t : o;
         h[p] = c[3:0] < 4'ha && ioa >= bt[c[3:0]]
            && ioa <= bt[c[3:0]] + 16'h0007;
         v[p] = ir[p] & c[7];
         d[p] = !xc[p] || (m[4 + p] ? pe[p] : !rt[p]);
      end
      return {o, t, m, it[t[6:4]], it[o[6:4]], h, v, d};
   endfunction
   // one register write; port one writes assume a non power-managed host
   task automatic wr(int s, logic [7:0] d);
      @(posedge clk);
      #1;
      wd = d;
      we1 = s == 0;
      we2 = s == 1;
      wem = s == 2;
      @(posedge clk);
      #1;
      {we1, we2, wem} = 3'h0;
      if (s == 0) o = d;
      else if (s == 1) t = d;
      else m = d & 8'h30;
   endtask
   // let outputs settle, then note the expectation
   task expect_now;
      repeat (3) @(posedge clk);
      #1;
      q.push_back(ex());
      chk = 1'b1;
      @(posedge clk);
      #1;
      chk = 1'b0;
   endtask
   task rst_chk;
      sys_rst = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      {o, t, m} = {8'h10, 8'h01, 8'h00};
      expect_now;
   endtask
   // monitor: oldest note against the outputs
   always @(posedge clk) begin
      if (chk && q.size() > 0)
         check({oc, tc, mr, il, hit, iv, td}, q.pop_front());
   end
   // main sequence
   initial begin
      void'($urandom(6565));
      rst_chk;
      $display("test reset defaults done");
      for (int i = 0; i < 16; i++) begin
         r = $urandom();
         wr(0, {r[7], i[2:0], i[3:0]});
         wr(1, {r[6], 3'(7 - i), 4'(15 - i)});
         cmd = {r[15:14], 6'h00};
         ioa = bt[i % 10] + r[18:16];
         expect_now;
      end
      $display("test base and line codes done");
      for (int i = 0; i < 24; i++) begin
         r = $urandom();
         wr(2, r[7:0]);
         cmd = r[15:8];
         expect_now;
      end
      $display("test direction control done");
      wr(0, 8'hff);
      wr(2, 8'hff);
      rst_chk;
      $display("test mid-run reset done");
      results;
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      $display("timeout");
      err_total++;
      results;
   end
endmodule // tb
`default_nettype wire
